// ===== pfs_pkg.sv
/*
  Package for the program flow sequencer: opcodes, wait types, widths,
  tick timing and the packed structs that carry instructions and axis status.
  Assumes one 100 MHz system clock shared by all users of the package.
*/
package pfs_pkg;
  localparam int PFS_AXES = 6;
  localparam int PFS_STACK_DEPTH = 8;
  localparam int PFS_SP_W = 4;
  localparam int PFS_PC_W = 32;
  // Opcodes
  localparam logic [7:0] PFS_OP_JUMP_ALWAYS = 8'h16;
  localparam logic [7:0] PFS_OP_CALL_SUB = 8'h17;
  localparam logic [7:0] PFS_OP_RETURN_SUB = 8'h18;
  localparam logic [7:0] PFS_OP_WAIT = 8'h1B;
  localparam logic [7:0] PFS_OP_JUMP_COND = 8'h15;
  localparam logic [7:0] PFS_JC_TIMEOUT = 8'h08;
  // Wait types
  localparam logic [7:0] PFS_WAIT_TICKS = 8'h00;
  localparam logic [7:0] PFS_WAIT_TARGET = 8'h01;
  localparam logic [7:0] PFS_WAIT_HOME_SWITCH = 8'h02;
  localparam logic [7:0] PFS_WAIT_END_SWITCH = 8'h03;
  localparam logic [7:0] PFS_WAIT_HOMING_DONE = 8'h04;
  localparam logic [31:0] PFS_VALUE_USE_ACC = 32'hFFFFFFFF;
  // Tick timing
  localparam int PFS_CLK_HZ = 100_000_000;
  localparam int PFS_TICK_MS = 10;
  localparam int PFS_TICK_CYCLES = PFS_CLK_HZ / 1000 * PFS_TICK_MS;
  localparam int PFS_PRESC_W = 20;
  localparam logic [PFS_PC_W-1:0] PFS_PC_RESET = 32'h00000000;

  // One instruction as handed in by the fetch logic
  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] kind;
    logic [7:0] motor;
    logic [31:0] value;
  } pfs_instr_t;

  // Per-axis status from the motion controller
  typedef struct packed {
    logic [PFS_AXES-1:0] target_reached;
    logic [PFS_AXES-1:0] home_switch;
    logic [PFS_AXES-1:0] end_switch_left;
    logic [PFS_AXES-1:0] end_switch_right;
    logic [PFS_AXES-1:0] homing_done;
  } pfs_axis_t;

  typedef enum logic [1:0] {
    PFS_ST_IDLE = 2'b00,
    PFS_ST_WAIT = 2'b01
  } pfs_state_t;
endpackage : pfs_pkg

// ===== pfs_tick_gen.sv
/*
  Free-running prescaler giving a one-cycle enable every 10 ms tick.
  Assumes the 100 MHz system clock and a synchronous active-high reset.
*/
`timescale 1ns/10ps
module pfs_tick_gen
  import pfs_pkg::*;
#(
  parameter int TICK_CYCLES = PFS_TICK_CYCLES
)
(
  input wire logic sys_clk_in,
  input wire logic rst_in,
  output logic tick_out
);
  logic [PFS_PRESC_W-1:0] cnt_q;
  wire last_w = (cnt_q == PFS_PRESC_W'(TICK_CYCLES - 1));

  // Count cycles and pulse on wrap
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      cnt_q <= '0;
      tick_out <= 1'b0;
    end
    else
    begin
      cnt_q <= last_w ? '0 : cnt_q + 1'b1;
      tick_out <= last_w;
    end
  end
endmodule : pfs_tick_gen

// ===== pfs_sequencer.sv
/*
  Program flow sequencer: jump, call, return with an 8-deep return stack,
  conditional jump on timeout, and the event/tick wait with timeout.
  Assumes instructions arrive one per exec strobe from the fetch logic and
  that axis status pins come from outside the clock domain.
// Operation
// - Jump loads program counter from value
// - Call pushes counter then jumps
// - Return stack holds eight entries
// - Call on full stack does nothing
// - Return pops and resumes after call
// - Return on empty stack does nothing
// - Wait holds counter until condition/timeout
// - Wait types zero to four decoded
// - Tick wait ignores motor, counts ticks
// - One tick lasts ten milliseconds
// - Type one waits for target reached
// - Type two waits for home switch
// - Type three waits either end switch
// - Type four waits homing done
// - Zero timeout means wait forever
// - Value minus one uses accumulator
// - Timeout sets sticky flag, continues
// - Only active in standalone execution
// - Conditional type eight tests timeout flag
*/
`timescale 1ns/10ps
module pfs_sequencer
  import pfs_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic exec_in,
  input wire logic standalone_in,
  input wire pfs_instr_t instr_in,
  input wire logic [31:0] pc_in,
  input wire logic [31:0] accu_in,
  input wire pfs_axis_t axis_in,
  input wire logic clear_error_in,
  output logic pc_load_out,
  output logic [31:0] pc_out,
  output logic hold_out,
  output logic busy_out,
  output logic timeout_error_flag_out,
  output logic [PFS_SP_W-1:0] depth_out
);
  logic [31:0] stack_q [PFS_STACK_DEPTH];
  logic [PFS_SP_W-1:0] sp_q;
  pfs_state_t state_q;
  logic [31:0] count_q;
  logic [7:0] kind_q;
  logic [2:0] motor_q;
  logic timed_q;
  logic tick_w;
  pfs_axis_t sync1_q;
  pfs_axis_t sync2_q;

  pfs_tick_gen u_tick
  (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .tick_out(tick_w)
  );

  // Two-stage synchroniser for the axis status pins
  always_ff @(posedge sys_clk_in)
  begin
    sync1_q <= axis_in;
    sync2_q <= sync1_q;
  end

  // Instruction decode
  wire go_w = exec_in & standalone_in & (state_q == PFS_ST_IDLE);
  wire is_jump_w = go_w & (instr_in.opcode == PFS_OP_JUMP_ALWAYS);
  wire is_call_w = go_w & (instr_in.opcode == PFS_OP_CALL_SUB);
  wire is_ret_w = go_w & (instr_in.opcode == PFS_OP_RETURN_SUB);
  wire is_wait_w = go_w & (instr_in.opcode == PFS_OP_WAIT)
    & (instr_in.kind <= PFS_WAIT_HOMING_DONE);
  wire is_jc_w = go_w & (instr_in.opcode == PFS_OP_JUMP_COND)
    & (instr_in.kind == PFS_JC_TIMEOUT) & timeout_error_flag_out;
  wire full_w = (sp_q == PFS_SP_W'(PFS_STACK_DEPTH));
  wire empty_w = (sp_q == '0);
  wire push_w = is_call_w & ~full_w;
  wire pop_w = is_ret_w & ~empty_w;
  wire [31:0] wval_w = (instr_in.value == PFS_VALUE_USE_ACC) ? accu_in
    : instr_in.value;
  wire [2:0] top_w = 3'(sp_q - 1'b1);

  // Condition select for the axis named by the wait
  wire [PFS_AXES-1:0] ends_w = sync2_q.end_switch_left | sync2_q.end_switch_right;
  wire ax_ok_w = (motor_q < 3'(PFS_AXES));
  wire ev_target_w = ax_ok_w & sync2_q.target_reached[motor_q];
  wire ev_home_w = ax_ok_w & sync2_q.home_switch[motor_q];
  wire ev_end_w = ax_ok_w & ends_w[motor_q];
  wire ev_homed_w = ax_ok_w & sync2_q.homing_done[motor_q];
  wire event_w = (kind_q == PFS_WAIT_TARGET) ? ev_target_w
    : (kind_q == PFS_WAIT_HOME_SWITCH) ? ev_home_w
    : (kind_q == PFS_WAIT_END_SWITCH) ? ev_end_w
    : (kind_q == PFS_WAIT_HOMING_DONE) ? ev_homed_w : 1'b0;
  wire tick_wait_w = (kind_q == PFS_WAIT_TICKS);
  wire expire_w = tick_w & (count_q == 32'h00000001);
  wire count_done_w = tick_wait_w & ((count_q == '0) | expire_w);
  wire timeout_w = ~tick_wait_w & timed_q & expire_w & ~event_w;
  wire wait_end_w = (state_q == PFS_ST_WAIT)
    & (count_done_w | (~tick_wait_w & event_w) | timeout_w);

  // Return stack entries
  always_ff @(posedge sys_clk_in)
  begin
    if (push_w)
      stack_q[sp_q[2:0]] <= pc_in;
  end

  // Stack pointer, emptied on reset
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
      sp_q <= '0;
    else if (push_w)
      sp_q <= sp_q + 1'b1;
    else if (pop_w)
      sp_q <= sp_q - 1'b1;
  end

  // Wait state and tick countdown
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      state_q <= PFS_ST_IDLE;
      count_q <= '0;
      kind_q <= '0;
      motor_q <= '0;
      timed_q <= 1'b0;
    end
    else if (is_wait_w)
    begin
      state_q <= PFS_ST_WAIT;
      count_q <= wval_w;
      kind_q <= instr_in.kind;
      motor_q <= instr_in.motor[2:0];
      timed_q <= (wval_w != '0);
    end
    else if (wait_end_w)
      state_q <= PFS_ST_IDLE;
    else if (state_q == PFS_ST_WAIT && tick_w && count_q != '0)
      count_q <= count_q - 1'b1;
  end

  // Sticky timeout flag; a new timeout wins over a clear
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
      timeout_error_flag_out <= 1'b0;
    else if (timeout_w)
      timeout_error_flag_out <= 1'b1;
    else if (clear_error_in)
      timeout_error_flag_out <= 1'b0;
  end

  // Program counter load requests
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      pc_load_out <= 1'b0;
      pc_out <= PFS_PC_RESET;
    end
    else
    begin
      pc_load_out <= is_jump_w | push_w | pop_w | is_jc_w;
      if (is_jump_w || push_w || is_jc_w)
        pc_out <= instr_in.value;
      else if (pop_w)
        pc_out <= stack_q[top_w];
    end
  end

  // Status outputs
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      hold_out <= 1'b0;
      busy_out <= 1'b0;
      depth_out <= '0;
    end
    else
    begin
      hold_out <= is_wait_w | ((state_q == PFS_ST_WAIT) & ~wait_end_w);
      busy_out <= is_wait_w | ((state_q == PFS_ST_WAIT) & ~wait_end_w);
      depth_out <= push_w ? sp_q + 1'b1 : pop_w ? sp_q - 1'b1 : sp_q;
    end
  end
endmodule : pfs_sequencer

// ===== pfs_sequencer_sva.sv
/*
  Port checker for the program flow sequencer.
  Assumes one clock and the bind at the foot of this file.
*/
`timescale 1ns/10ps
module pfs_chk
  import pfs_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic exec_in,
  input wire logic standalone_in,
  input wire pfs_instr_t instr_in,
  input wire logic clear_error_in,
  input wire logic pc_load_out,
  input wire logic [31:0] pc_out,
  input wire logic hold_out,
  input wire logic timeout_error_flag_out,
  input wire logic [PFS_SP_W-1:0] depth_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  // Accepted request decode
  wire take_w = exec_in && standalone_in && !hold_out;
  wire [7:0] op_w = instr_in.opcode;
  wire full_w = depth_out == 4'h8;
  chk_jump_load: assert property (
    take_w && op_w == PFS_OP_JUMP_ALWAYS |=> pc_load_out && pc_out == $past(instr_in.value))
    else $error("jump target wrong");
  chk_call_push: assert property (take_w && op_w == PFS_OP_CALL_SUB && !full_w |=>
    pc_load_out && depth_out == $past(depth_out) + 4'h1) else $error("call push wrong");
  chk_call_full: assert property (take_w && op_w == PFS_OP_CALL_SUB && full_w |=>
    !pc_load_out && full_w) else $error("call on full stack acted");
  chk_ret_pop: assert property (take_w && op_w == PFS_OP_RETURN_SUB && depth_out != 4'h0 |=>
    pc_load_out && depth_out == $past(depth_out) - 4'h1) else $error("return pop wrong");
  chk_ret_empty: assert property (take_w && op_w == PFS_OP_RETURN_SUB && depth_out == 4'h0 |=>
    !pc_load_out && depth_out == 4'h0) else $error("return on empty acted");
  chk_mode_only: assert property (exec_in && !standalone_in && !hold_out |=> !pc_load_out)
    else $error("direct mode executed");
  chk_wait_hold: assert property (take_w && op_w == PFS_OP_WAIT && instr_in.kind != 8'h00
    && instr_in.kind < 8'h05 && instr_in.value == 32'h0 |=> hold_out) else $error("wait not held");
  chk_jc_flag: assert property (take_w && op_w == PFS_OP_JUMP_COND && instr_in.kind == 8'h08
    |=> pc_load_out == $past(timeout_error_flag_out)) else $error("timeout branch wrong");
  chk_flag_sticky: assert property (timeout_error_flag_out && !clear_error_in
    |=> timeout_error_flag_out) else $error("flag lost");
  chk_reset_clear: assert property (disable iff (1'h0) rst_in |=>
    depth_out == 4'h0 && !timeout_error_flag_out && !hold_out) else $error("reset left state");
  // Main scenarios
  cov_full: cover property (take_w && op_w == PFS_OP_CALL_SUB && full_w);
  cov_empty: cover property (take_w && op_w == PFS_OP_RETURN_SUB && depth_out == 4'h0);
  cov_wait_end: cover property ($fell(hold_out));
endmodule : pfs_chk
bind pfs_sequencer pfs_chk u_chk (.sys_clk_in, .rst_in, .exec_in, .standalone_in, .instr_in,
  .clear_error_in, .pc_load_out, .pc_out, .hold_out, .timeout_error_flag_out, .depth_out);

// ===== pfs_axis_model.sv
/*
  Axis status model: raises one event of one axis while asked.
  Assumes requests change just after a rising edge.
*/
`timescale 1ns/10ps
module pfs_axis_model
  import pfs_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic fire_in,
  input wire logic [2:0] sel_in,
  input wire logic [2:0] ax_in,
  output pfs_axis_t axis_out
);
  pfs_axis_t axis_q;
  // Selected event held while requested, else all quiet
  always_ff @(posedge sys_clk_in)
  begin
    axis_q <= '0;
    if (fire_in && sel_in == 3'h1)
      axis_q.target_reached[ax_in] <= 1'h1;
    if (fire_in && sel_in == 3'h2)
      axis_q.home_switch[ax_in] <= 1'h1;
    if (fire_in && sel_in == 3'h3)
      axis_q.end_switch_left[ax_in] <= 1'h1;
    if (fire_in && sel_in == 3'h4)
      axis_q.homing_done[ax_in] <= 1'h1;
  end
  assign axis_out = axis_q;
endmodule : pfs_axis_model

// ===== pfs_testbench.sv
/*
  Random and corner tests of the sequencer with the axis model.
  Assumes a 100 MHz clock; a tick is too long to elapse in this run.
*/
`timescale 1ns/10ps
module testbench
  import pfs_pkg::*;
;
  logic sys_clk_in = 1'h0;
  logic rst_in = 1'h1;
  logic exec_in = 1'h0;
  logic standalone_in = 1'h1;
  logic clear_error_in = 1'h0;
  logic fire = 1'h0;
  logic [2:0] sel = 3'h0;
  logic [2:0] ax = 3'h0;
  logic [31:0] pc_in = 32'h0;
  logic [31:0] accu_in = 32'h5;
  pfs_instr_t instr_in = '0;
  pfs_axis_t axis_in;
  logic pc_load_out, hold_out, busy_out, timeout_error_flag_out;
  logic [31:0] pc_out;
  logic [PFS_SP_W-1:0] depth_out;
  logic [31:0] stk[$];
  int errors = 0;
  int num_checks = 0;
  int seed = 16322;
  int i;
  pfs_axis_model u_axis (.sys_clk_in, .fire_in(fire), .sel_in(sel), .ax_in(ax), .axis_out(axis_in));
  pfs_sequencer u_dut (.sys_clk_in, .rst_in, .exec_in, .standalone_in, .instr_in, .pc_in,
    .accu_in, .axis_in, .clear_error_in, .pc_load_out, .pc_out, .hold_out, .busy_out,
    .timeout_error_flag_out, .depth_out);
  // Clock
  initial
    forever #5 sys_clk_in = ~sys_clk_in;
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] %s exp %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic final_report;
    if (errors == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : final_report
  // One exec pulse, outputs sampled once settled
  task automatic run(input logic [7:0] op, input logic [7:0] kind, input logic [31:0] val);
    @(posedge sys_clk_in);
    exec_in <= 1'h1;
    instr_in <= '{op, kind, {5'h00, ax}, val};
    pc_in <= $random(seed);
    @(posedge sys_clk_in);
    exec_in <= 1'h0;
    #1;
  endtask : run
  function automatic logic exp_load(input logic [7:0] op, input int d);
    return op == PFS_OP_JUMP_ALWAYS || (op == PFS_OP_CALL_SUB && d < PFS_STACK_DEPTH)
      || (op == PFS_OP_RETURN_SUB && d > 0);
  endfunction : exp_load
  task automatic step(input logic [7:0] op, input logic [31:0] val);
    logic ld;
    logic [31:0] tgt;
    ld = exp_load(op, stk.size());
    tgt = val;
    run(op, 8'h00, val);
    if (ld && op == PFS_OP_CALL_SUB)
      stk.push_back(pc_in);
    if (ld && op == PFS_OP_RETURN_SUB)
      tgt = stk.pop_back();
    check("pc_load", 32'(pc_load_out), 32'(ld));
    if (ld)
      check("pc", pc_out, tgt);
    check("depth", 32'(depth_out), 32'(stk.size()));
  endtask : step
  // Watchdog
  initial
  begin
    #100000;
    errors++;
    final_report();
  end
  initial
  begin
    repeat (2) @(posedge sys_clk_in);
    rst_in <= 1'h0;
    for (i = 0; i < 18; i++)
      step(i < 9 ? PFS_OP_CALL_SUB : PFS_OP_RETURN_SUB, $random(seed));
    for (i = 0; i < 40; i++)
      step(PFS_OP_JUMP_ALWAYS + 8'($unsigned($random(seed)) % 3), $random(seed));
    for (i = 1; i < 5; i++)
    begin
      ax <= 3'($unsigned($random(seed)) % 6);
      run(PFS_OP_WAIT, 8'(i), 32'h0);
      repeat (20) @(posedge sys_clk_in);
      #1;
      check("hold", 32'(hold_out), 32'h1);
      check("busy", 32'(busy_out), 32'h1);
      sel <= 3'(i);
      fire <= 1'h1;
      for (int n = 0; n < 10 && hold_out; n++)
        @(posedge sys_clk_in);
      fire <= 1'h0;
      #1;
      check("hold_end", 32'(hold_out), 32'h0);
    end
    standalone_in <= 1'h0;
    run(PFS_OP_JUMP_ALWAYS, 8'h00, 32'h0);
    check("mode", 32'(pc_load_out), 32'h0);
    standalone_in <= 1'h1;
    clear_error_in <= 1'h1;
    run(PFS_OP_JUMP_COND, PFS_JC_TIMEOUT, 32'h0);
    clear_error_in <= 1'h0;
    check("jc", 32'(pc_load_out), 32'h0);
    check("flag", 32'(timeout_error_flag_out), 32'h0);
    step(PFS_OP_CALL_SUB, 32'h10);
    run(PFS_OP_WAIT, PFS_WAIT_TICKS, 32'h0);
    repeat (3) @(posedge sys_clk_in);
    #1;
    check("tick0", 32'(hold_out), 32'h0);
    run(PFS_OP_WAIT, 8'h05, 32'h0);
    check("kind5", 32'(hold_out), 32'h0);
    run(PFS_OP_WAIT, PFS_WAIT_TICKS, PFS_VALUE_USE_ACC);
    repeat (20) @(posedge sys_clk_in);
    #1;
    check("acc", 32'(hold_out), 32'h1);
    rst_in <= 1'h1;
    @(posedge sys_clk_in);
    rst_in <= 1'h0;
    #1;
    check("rst_depth", 32'(depth_out), 32'h0);
    check("rst_hold", 32'(hold_out), 32'h0);
    final_report();
  end
endmodule : testbench
